// ===== hdl/tpc_pkg.sv
// tpc_pkg: shared constants of the timer based pwm channel block
package tpc_pkg;
    // channel count and widths
    localparam int TPC_CHANS = 2;
    localparam int TPC_AW = 5;
    localparam int TPC_DW = 8;
    localparam int TPC_TBW = 10;
    // register offsets
    localparam logic [4:0] TPC_ADDR_PERIOD = 5'h00;
    localparam logic [4:0] TPC_ADDR_TCTL = 5'h01;
    localparam logic [4:0] TPC_ADDR_COUNT = 5'h02;
    localparam logic [4:0] TPC_ADDR_TSTAT = 5'h03;
    localparam logic [4:0] TPC_ADDR_OUTS = 5'h04;
    localparam logic [4:0] TPC_ADDR_CH_BASE = 5'h08;
    localparam logic [4:0] TPC_ADDR_CH_STEP = 5'h04;
    localparam logic [1:0] TPC_SUB_CCTL = 2'h0;
    localparam logic [1:0] TPC_SUB_DHI = 2'h1;
    localparam logic [1:0] TPC_SUB_DLO = 2'h2;
    // field positions
    localparam int TPC_TCTL_ON_BIT = 0;
    localparam int TPC_TCTL_PRE_LSB = 1;
    localparam int TPC_TCTL_POST_LSB = 3;
    localparam int TPC_TSTAT_POST_BIT = 0;
    localparam int TPC_CCTL_EN_BIT = 7;
    localparam int TPC_CCTL_OUT_BIT = 5;
    localparam int TPC_CCTL_INV_BIT = 4;
    localparam int TPC_DLO_LSB = 6;
    // reset values
    localparam logic [7:0] TPC_PERIOD_RST = 8'hFF;
    localparam logic [7:0] TPC_TCTL_RST = 8'h00;
    localparam logic [7:0] TPC_CCTL_RST = 8'h00;
    localparam logic [7:0] TPC_DUTY_RST = 8'h00;
    // writable bits of the channel control and duty low registers
    localparam logic [7:0] TPC_CCTL_WMASK = 8'h90;
    localparam logic [7:0] TPC_DLO_WMASK = 8'hC0;
    // timing: oscillator periods per timer step, prescale terminal counts
    localparam int TPC_OSC_PER_STEP = 4;
    localparam logic [5:0] TPC_PRE_TERM_1 = 6'h00;
    localparam logic [5:0] TPC_PRE_TERM_4 = 6'h03;
    localparam logic [5:0] TPC_PRE_TERM_16 = 6'h0F;
    localparam logic [5:0] TPC_PRE_TERM_64 = 6'h3F;
    // prescale selections
    typedef enum logic [1:0] {
        TPC_PRE_1 = 2'h0,
        TPC_PRE_4 = 2'h1,
        TPC_PRE_16 = 2'h3,
        TPC_PRE_64 = 2'h2
    } tpc_pre_t;
endpackage : tpc_pkg

// ===== hdl/tpc_pwm_chan.sv
// tpc_pwm_chan: one pwm channel with buffered duty and polarity
`timescale 1ns/1ps
module tpc_pwm_chan
    import tpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wrap,
    input wire logic tb_step,
    input wire logic [TPC_TBW-1:0] tb_nxt,
    input wire logic [7:0] period,
    input wire logic [7:0] duty_hi,
    input wire logic [1:0] duty_lo,
    input wire logic enable,
    input wire logic invert,
    output logic act,
    output logic pin
);
    logic [TPC_TBW-1:0] buf_r;
    logic act_r;
    logic pin_r;
    logic act_nxt;
    wire [TPC_TBW-1:0] duty_new = {duty_hi, duty_lo};
    wire [TPC_TBW:0] full_lim = {1'b0, period, 2'h0} + 11'h004;
    wire full = {1'b0, buf_r} >= full_lim;
    wire match = tb_step && (tb_nxt == buf_r);

    // next active state of the waveform
    always_comb begin
        act_nxt = act_r;
        if (!enable) begin
            act_nxt = 1'b0;
        end else if (wrap) begin
            act_nxt = (duty_new != 10'h000);
        end else if (match && !full) begin
            act_nxt = 1'b0;
        end
    end

    // duty buffer loads only at the period wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buf_r <= 10'h000;
            act_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            if (wrap) begin
                buf_r <= duty_new;
            end
            act_r <= act_nxt;
            pin_r <= act_nxt ^ invert;
        end
    end

    assign act = act_r;
    assign pin = pin_r;

    property p_wrap_set;
        @(posedge core_clk) disable iff (rst)
        wrap && enable && (duty_new != 10'h000) |=> act_r;
    endproperty
    a_wrap_set: assert property (p_wrap_set)
        else $error("output not active after wrap");

    property p_zero_duty;
        @(posedge core_clk) disable iff (rst)
        wrap && (duty_new == 10'h000) |=> !act_r;
    endproperty
    a_zero_duty: assert property (p_zero_duty)
        else $error("zero duty made output active");

    property p_buf_load;
        @(posedge core_clk) disable iff (rst)
        wrap |=> buf_r == $past(duty_new);
    endproperty
    a_buf_load: assert property (p_buf_load)
        else $error("duty buffer not loaded at wrap");

    property p_buf_hold;
        @(posedge core_clk) disable iff (rst)
        !wrap |=> $stable(buf_r);
    endproperty
    a_buf_hold: assert property (p_buf_hold)
        else $error("duty buffer changed between wraps");

    property p_match_clr;
        @(posedge core_clk) disable iff (rst)
        !wrap && match && !full |=> !act_r ##1 (!act_r || $past(wrap));
    endproperty
    a_match_clr: assert property (p_match_clr)
        else $error("output not cleared at duty match");

    property p_full_hold;
        @(posedge core_clk) disable iff (rst)
        act_r && full && enable && !wrap |=> act_r;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("full duty output was cleared");

    property p_polarity;
        @(posedge core_clk) disable iff (rst)
        ##1 pin_r == (act_r ^ $past(invert));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin level does not follow polarity");
endmodule : tpc_pwm_chan

// ===== hdl/tpc_pwm_top.sv
// tpc_pwm_top: shared period timer, register file and pwm channels
`timescale 1ns/1ps
module tpc_pwm_top
    import tpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [TPC_AW-1:0] reg_addr,
    input wire logic [TPC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [TPC_DW-1:0] reg_rdata,
    output logic [TPC_CHANS-1:0] pwm_out
);
    // timer state
    logic [7:0] period_limit_reg_r;
    logic [7:0] tctl_r;
    logic [7:0] shared_timer_count_r;
    logic [1:0] phase_r;
    logic [5:0] pre_cnt_r;
    logic [3:0] post_cnt_r;
    logic post_flag_r;
    logic [TPC_DW-1:0] rdata_r;
    // per channel software registers
    logic [7:0] channel_control_reg_r [TPC_CHANS];
    logic [7:0] duty_high_reg_r [TPC_CHANS];
    logic [7:0] duty_low_reg_r [TPC_CHANS];
    logic [TPC_CHANS-1:0] ch_act;
    logic [TPC_CHANS-1:0] ch_pin;

    // timer control fields
    wire timer_on = tctl_r[TPC_TCTL_ON_BIT];
    wire [1:0] pre_sel = tctl_r[TPC_TCTL_PRE_LSB +: 2];
    wire [3:0] post_sel = tctl_r[TPC_TCTL_POST_LSB +: 4];

    // prescale terminal count from the selection
    wire [5:0] pre_term =
        (pre_sel == TPC_PRE_1) ? TPC_PRE_TERM_1 :
        (pre_sel == TPC_PRE_4) ? TPC_PRE_TERM_4 :
        (pre_sel == TPC_PRE_16) ? TPC_PRE_TERM_16 : TPC_PRE_TERM_64;

    // one-cycle enables of the divider chain
    wire pre_tick = timer_on && (pre_cnt_r >= pre_term);
    wire tmr_step = pre_tick && (phase_r == 2'h3);
    wire wrap = tmr_step && (shared_timer_count_r == period_limit_reg_r);

    // ten bit time base and its next value
    wire [TPC_TBW-1:0] tb = {shared_timer_count_r, phase_r};
    wire [TPC_TBW-1:0] tb_inc = tb + 10'h001;
    wire [TPC_TBW-1:0] tb_nxt =
        wrap ? 10'h000 : (pre_tick ? tb_inc : tb);

    // register address decode
    wire in_ch = (reg_addr[4:3] == TPC_ADDR_CH_BASE[4:3]);
    wire ch_sel = reg_addr[2];
    wire [1:0] sub = reg_addr[1:0];
    wire wr_period = reg_wr && (reg_addr == TPC_ADDR_PERIOD);
    wire wr_tctl = reg_wr && (reg_addr == TPC_ADDR_TCTL);
    wire wr_count = reg_wr && (reg_addr == TPC_ADDR_COUNT);
    wire wr_tstat = reg_wr && (reg_addr == TPC_ADDR_TSTAT);
    wire post_clr = wr_tstat && reg_wdata[TPC_TSTAT_POST_BIT];
    wire post_hit = wrap && (post_cnt_r == post_sel);

    // period and timer control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            period_limit_reg_r <= TPC_PERIOD_RST;
            tctl_r <= TPC_TCTL_RST;
        end else begin
            if (wr_period) begin
                period_limit_reg_r <= reg_wdata;
            end
            if (wr_tctl) begin
                tctl_r <= reg_wdata;
            end
        end
    end

    // shared count and phase bits; a count write restarts the phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shared_timer_count_r <= 8'h00;
            phase_r <= 2'h0;
        end else if (wr_count) begin
            shared_timer_count_r <= reg_wdata;
            phase_r <= 2'h0;
        end else begin
            shared_timer_count_r <= tb_nxt[9:2];
            phase_r <= tb_nxt[1:0];
        end
    end

    // prescaler divider
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= 6'h00;
        end else if (!timer_on || pre_tick || wr_count) begin
            pre_cnt_r <= 6'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
        end
    end

    // postscaler counts wraps into a sticky flag only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            post_cnt_r <= 4'h0;
            post_flag_r <= 1'b0;
        end else begin
            if (post_hit) begin
                post_cnt_r <= 4'h0;
            end else if (wrap) begin
                post_cnt_r <= post_cnt_r + 4'h1;
            end
            if (post_hit) begin
                post_flag_r <= 1'b1;
            end else if (post_clr) begin
                post_flag_r <= 1'b0;
            end
        end
    end

    // per channel registers and channel instances share one wrap
    generate
        for (genvar i = 0; i < TPC_CHANS; i++) begin : g_ch
            wire hit = in_ch && (ch_sel == 1'(i));
            wire wr_cctl = reg_wr && hit && (sub == TPC_SUB_CCTL);
            wire wr_dhi = reg_wr && hit && (sub == TPC_SUB_DHI);
            wire wr_dlo = reg_wr && hit && (sub == TPC_SUB_DLO);

            // software copies; writes allowed at any time
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    channel_control_reg_r[i] <= TPC_CCTL_RST;
                    duty_high_reg_r[i] <= TPC_DUTY_RST;
                    duty_low_reg_r[i] <= TPC_DUTY_RST;
                end else begin
                    if (wr_cctl) begin
                        channel_control_reg_r[i] <=
                            reg_wdata & TPC_CCTL_WMASK;
                    end
                    if (wr_dhi) begin
                        duty_high_reg_r[i] <= reg_wdata;
                    end
                    if (wr_dlo) begin
                        duty_low_reg_r[i] <=
                            reg_wdata & TPC_DLO_WMASK;
                    end
                end
            end

            tpc_pwm_chan u_chan (
                .core_clk(core_clk),
                .rst(rst),
                .wrap(wrap),
                .tb_step(pre_tick),
                .tb_nxt(tb_nxt),
                .period(period_limit_reg_r),
                .duty_hi(duty_high_reg_r[i]),
                .duty_lo(duty_low_reg_r[i][TPC_DLO_LSB +: 2]),
                .enable(channel_control_reg_r[i][TPC_CCTL_EN_BIT]),
                .invert(channel_control_reg_r[i][TPC_CCTL_INV_BIT]),
                .act(ch_act[i]),
                .pin(ch_pin[i])
            );
        end
    endgenerate

    // channel register read selection
    wire [7:0] ch_cctl_rd = channel_control_reg_r[ch_sel]
        | ({7'h00, ch_act[ch_sel]} << TPC_CCTL_OUT_BIT);
    wire [7:0] ch_rd =
        (sub == TPC_SUB_CCTL) ? ch_cctl_rd :
        (sub == TPC_SUB_DHI) ? duty_high_reg_r[ch_sel] :
        (sub == TPC_SUB_DLO) ? duty_low_reg_r[ch_sel] : 8'h00;

    // full read selection; unmapped offsets read zero
    wire [7:0] rd_mux =
        in_ch ? ch_rd :
        (reg_addr == TPC_ADDR_PERIOD) ? period_limit_reg_r :
        (reg_addr == TPC_ADDR_TCTL) ? tctl_r :
        (reg_addr == TPC_ADDR_COUNT) ? shared_timer_count_r :
        (reg_addr == TPC_ADDR_TSTAT) ? {7'h00, post_flag_r} :
        (reg_addr == TPC_ADDR_OUTS) ? {{(8-TPC_CHANS){1'b0}}, ch_pin} :
        8'h00;

    // read data stand for one cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign pwm_out = ch_pin;

    // helper: clocks since the last wrap and a clean-period marker
    logic [16:0] per_cnt_r;
    logic clean_r;
    wire [16:0] per_exp = 17'(({9'h000, period_limit_reg_r} + 17'h1)
        * 17'(TPC_OSC_PER_STEP) * ({11'h000, pre_term} + 17'h1));
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            per_cnt_r <= 17'h00000;
            clean_r <= 1'b0;
        end else begin
            per_cnt_r <= wrap ? 17'h00000 : per_cnt_r + 17'h00001;
            if (wr_period || wr_tctl || wr_count) begin
                clean_r <= 1'b0;
            end else if (wrap) begin
                clean_r <= 1'b1;
            end
        end
    end

    property p_period_len;
        @(posedge core_clk) disable iff (rst)
        wrap && clean_r && !wr_period && !wr_tctl
            |-> per_cnt_r == per_exp - 17'h00001;
    endproperty
    a_period_len: assert property (p_period_len)
        else $error("pwm period length wrong");

    property p_wrap_zero;
        @(posedge core_clk) disable iff (rst)
        wrap && !wr_count |=> tb == 10'h000;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("time base not zero after wrap");

    property p_step;
        @(posedge core_clk) disable iff (rst)
        tmr_step && !wrap && !wr_count
            |=> shared_timer_count_r == $past(shared_timer_count_r) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("timer count did not advance");

    property p_direct;
        @(posedge core_clk) disable iff (rst)
        timer_on && (pre_sel == TPC_PRE_1) && !wr_count
            |=> phase_r == $past(phase_r) + 2'h1;
    endproperty
    a_direct: assert property (p_direct)
        else $error("undivided prescale did not tick");

    property p_rd_idle;
        @(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");

    property p_off_hold;
        @(posedge core_clk) disable iff (rst)
        !timer_on && !wr_count |=> $stable(tb);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("time base moved with timer off");

    property p_post_set;
        @(posedge core_clk) disable iff (rst)
        post_hit |=> post_flag_r;
    endproperty
    a_post_set: assert property (p_post_set)
        else $error("postscale flag not set");

    property p_post_clr;
        @(posedge core_clk) disable iff (rst)
        post_clr && !post_hit |=> !post_flag_r;
    endproperty
    a_post_clr: assert property (p_post_clr)
        else $error("postscale flag not cleared");

    property p_rd_period;
        @(posedge core_clk) disable iff (rst)
        reg_rd && (reg_addr == TPC_ADDR_PERIOD)
            |=> reg_rdata == $past(period_limit_reg_r);
    endproperty
    a_rd_period: assert property (p_rd_period)
        else $error("period read back wrong");

    // channel 0 control bits watched by the gate check
    wire ch0_en = channel_control_reg_r[0][TPC_CCTL_EN_BIT];
    wire ch0_inv = channel_control_reg_r[0][TPC_CCTL_INV_BIT];

    property p_off_gate;
        @(posedge core_clk) disable iff (rst)
        !ch0_en |=> pwm_out[0] == $past(ch0_inv);
    endproperty
    a_off_gate: assert property (p_off_gate)
        else $error("disabled channel pin not at idle level");
endmodule : tpc_pwm_top

// ===== sim/test_timer_based_pwm_channel.sv
// test_timer_based_pwm_channel: self-checking bench of the pwm block
`timescale 1ns/1ps
module test_timer_based_pwm_channel
    import tpc_pkg::*;
;
    logic core_clk;
    logic rst;
    logic [TPC_AW-1:0] reg_addr;
    logic [TPC_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [TPC_DW-1:0] reg_rdata;
    logic [TPC_CHANS-1:0] pwm_out;
    logic [15:0] hi0, per0, hi1, per1;
    logic [7:0] rd_val;
    int err_count;
    int samples_checked;
    int ones;

    tpc_pwm_top uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_out(pwm_out));
    tpc_load_model m0 (.core_clk(core_clk), .rst(rst), .pin(pwm_out[0]),
        .hi_len(hi0), .per_len(per0));
    tpc_load_model m1 (.core_clk(core_clk), .rst(rst), .pin(pwm_out[1]),
        .hi_len(hi1), .per_len(per1));

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    task wrap_up;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // one-cycle bus write and read
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    function automatic logic [4:0] ch_addr(input int ch, input logic [1:0] s);
        return TPC_ADDR_CH_BASE + 5'(ch * TPC_ADDR_CH_STEP) + {3'h0, s};
    endfunction : ch_addr

    // duty split into high byte and low byte top bits
    task set_duty(input int ch, input logic [9:0] v);
        wr(ch_addr(ch, TPC_SUB_DHI), v[9:2]);
        wr(ch_addr(ch, TPC_SUB_DLO), {v[1:0], 6'h00});
    endtask : set_duty

    task wait_pin(input int ch, input logic lvl);
        int i;
        i = 0;
        while (pwm_out[ch] !== lvl && i < 2000) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 2000) begin
            err_count++;
            $display("Error at %0t: pin wait ran out", $time);
            wrap_up();
        end
    endtask : wait_pin

    task count_ones(input int ch, input int n);
        ones = 0;
        repeat (n) begin
            @(posedge core_clk);
            if (pwm_out[ch] === 1'b1) ones++;
        end
    endtask : count_ones

    // period reset value, unmapped read, low duty mask
    task t_regs;
        rd(TPC_ADDR_PERIOD, rd_val);
        check({8'h00, rd_val}, {8'h00, TPC_PERIOD_RST});
        rd(5'h1F, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        wr(ch_addr(0, TPC_SUB_DLO), 8'hFF);
        rd(ch_addr(0, TPC_SUB_DLO), rd_val);
        check({8'h00, rd_val}, 16'h00C0);
    endtask : t_regs

    // period 3 at 1:1: 16 clocks, two independent duties
    task t_basic;
        wr(TPC_ADDR_PERIOD, 8'h03);
        set_duty(0, 10'h005);
        set_duty(1, 10'h00A);
        wr(ch_addr(0, TPC_SUB_CCTL), 8'h80);
        wr(ch_addr(1, TPC_SUB_CCTL), 8'h80);
        wr(TPC_ADDR_TCTL, 8'h01);
        repeat (48) @(posedge core_clk);
        check(per0, 16'd16);
        check(hi0, 16'd5);
        check(per1, 16'd16);
        check(hi1, 16'd10);
    endtask : t_basic

    // postscale at its largest leaves timing alone
    task t_post;
        wr(TPC_ADDR_TCTL, 8'h79);
        repeat (48) @(posedge core_clk);
        check(per0, 16'd16);
        check(hi0, 16'd5);
        rd(TPC_ADDR_TSTAT, rd_val);
        check({8'h00, rd_val}, 16'h0001);
        wr(TPC_ADDR_TSTAT, 8'h01);
        rd(TPC_ADDR_TSTAT, rd_val);
        check({8'h00, rd_val}, 16'h0000);
    endtask : t_post

    // 1:4 prescale: 64 clock period, 20 clock pulse
    task t_pre;
        wr(TPC_ADDR_TCTL, 8'h03);
        repeat (192) @(posedge core_clk);
        check(per0, 16'd64);
        check(hi0, 16'd20);
        wr(TPC_ADDR_TCTL, 8'h01);
        repeat (48) @(posedge core_clk);
    endtask : t_pre

    // duty rewritten inside a pulse takes effect at the next wrap
    task t_buf;
        wait_pin(0, 1'b0);
        wait_pin(0, 1'b1);
        set_duty(0, 10'h009);
        wait_pin(0, 1'b0);
        repeat (2) @(posedge core_clk);
        check(hi0, 16'd5);
        repeat (32) @(posedge core_clk);
        check(hi0, 16'd9);
    endtask : t_buf

    // duty at full period and at zero
    task t_full;
        set_duty(0, 10'h010);
        repeat (32) @(posedge core_clk);
        count_ones(0, 64);
        check(16'(ones), 16'd64);
        count_ones(1, 64);
        check(16'(ones), 16'd40);
        set_duty(0, 10'h000);
        repeat (32) @(posedge core_clk);
        count_ones(0, 64);
        check(16'(ones), 16'd0);
    endtask : t_full

    // inverted output: high time is the complement
    task t_inv;
        set_duty(0, 10'h005);
        wr(ch_addr(0, TPC_SUB_CCTL), 8'h90);
        repeat (32) @(posedge core_clk);
        count_ones(0, 64);
        check(16'(ones), 16'd44);
    endtask : t_inv

    // main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_basic();
        t_post();
        t_pre();
        t_buf();
        t_full();
        t_inv();
        wrap_up();
    end
endmodule : test_timer_based_pwm_channel

// ===== sim/tpc_load_model.sv
// tpc_load_model: external load timing the pulses on one pwm pin
`timescale 1ns/1ps
module tpc_load_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pin,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    logic prev_r;
    logic [15:0] cnt_r;

    // pin is driven as an output; rise to rise and rise to fall lengths
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            cnt_r <= 16'h0000;
            hi_len <= 16'h0000;
            per_len <= 16'h0000;
        end else begin
            prev_r <= pin;
            cnt_r <= cnt_r + 16'h0001;
            if (pin && !prev_r) begin
                per_len <= cnt_r; // whole waveform period
                cnt_r <= 16'h0001;
            end
            if (!pin && prev_r) begin
                hi_len <= cnt_r; // active pulse length
            end
        end
    end
endmodule : tpc_load_model
